// ### rtl/bed_top.sv
// Bus event detector: registers, channels, sequencing and actions
//
// Functional notes
// R1: Twelve event points, full plus range channels
// R2: Full channels match address, data, class, probes
// R3: Range channels have delay but no count
// R4: Up to eight channels chained in sequence
// R5: Hardware capture; few cycles match to action
// R6: Event halts, or starts/stops timer or trace
// R7: 256 software breakpoints halt on fetch
// R8: ROM has one breakpoint, halts after execution
// R9: Bus class: prefetch, data, refresh, DMA, transfer, other
// R10: Area class from target signals, seven areas
// R11: Class drives suppression, access count, trace record
// R12: Channel 8 drives trigger low one bus cycle
// R13: Mask ANDs bus data and reference alike
// R14: Enabled terms ANDed, don't care always true
// R15: Count reached fires; delay postpones action
`timescale 1ns/1ps
`default_nettype none
module bed_top #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [bed_pkg::REG_AW-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Target bus cycle
	input wire logic bus_valid_in,
	input wire logic [ADDR_W-1:0] bus_addr_in,
	input wire logic [DATA_W-1:0] bus_data_in,
	input wire logic bus_write_in,
	input wire logic bus_word_in,
	input wire logic [2:0] bus_class_in,
	input wire logic [2:0] bus_area_in,
	input wire logic [3:0] probe_in,
	// Actions
	output logic break_out,
	output logic timer_run_out,
	output logic trace_en_out,
	output logic [2:0] trace_class_out,
	output logic trigger_output_probe_n_out,
	output logic irq_out
);
	import bed_pkg::*;

	// Address and data must fit the 32-bit register words
	if (ADDR_W < 1 || ADDR_W > 31 || DATA_W < 1 || DATA_W > 32)
	begin : g_bad_width
		$error("bed_top: unsupported ADDR_W or DATA_W");
	end

	// Channel configuration words
	logic [31:0] ctl [NUM_CH];
	logic [31:0] lo [NUM_CH];
	logic [31:0] hi [NUM_CH];
	logic [31:0] dref [NUM_CH];
	logic [31:0] dmask [NUM_CH];
	logic [31:0] act [NUM_CH];
	logic [31:0] cnt [NUM_CH];
	logic [31:0] dly [NUM_CH];
	// Global state
	logic [ST_W-1:0] status; // Sticky event flags
	logic [ST_W-1:0] mask; // Interrupt enables
	logic [31:0] ocb_addr; // On-chip breakpoint address
	logic [1:0] brk_ctl; // Table and on-chip enables
	logic [7:0] sw_idx; // Table entry pointer
	logic [NUM_FULL-1:0] fired; // Sequence stages done
	logic [5:0] suppress; // Classes kept out of trace
	logic [5:0] acc_type; // Classes counted in range
	logic [31:0] acc_cnt; // Accesses counted in range
	logic timer_run; // Run timer active
	logic trace_run; // Trace window open

	// Address decode
	wire logic [3:0] ch_f = reg_addr_in[CH_LSB +: 4];
	wire logic [3:0] reg_f = reg_addr_in[REG_LSB +: 4];
	wire logic ch_ok = ch_f < 4'(NUM_CH) && reg_f <= R_DLY;
	wire logic glb = ch_f == CH_GLOBAL;
	wire logic gw = reg_wr_in && glb;
	wire logic wr_status = gw && reg_f == G_STATUS;
	wire logic wr_entry = gw && reg_f == G_SW_ENTRY;
	wire logic wr_seq_clr = gw && reg_f == G_SEQ_CLR;
	wire logic wr_acc = gw && reg_f == G_ACC_CNT;

	// Channel events and hardware hits
	logic [NUM_CH-1:0] ev;
	logic [NUM_CH-1:0] arm;
	logic sw_hit;
	logic ocb_hit;

	// Per channel action masks
	logic [NUM_CH-1:0] a_brk, a_tstart, a_tstop, a_trstart, a_trstop;

	// Channels: full ones count and chain, range ones only delay
	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_ch
		localparam bit FULL = g < NUM_FULL;
		assign a_brk[g] = act[g][A_BREAK];
		assign a_tstart[g] = act[g][A_TSTART];
		assign a_tstop[g] = act[g][A_TSTOP];
		assign a_trstart[g] = act[g][A_TRSTART];
		assign a_trstop[g] = act[g][A_TRSTOP];
		// A stage waits for the stage before it
		if (FULL && g > 0)
		begin : g_seq
			assign arm[g] = !act[g][A_SEQ] || fired[g-1]; // R4
		end
		else
		begin : g_free
			assign arm[g] = 1'b1;
		end
		bed_channel #(
			.ADDR_W(ADDR_W),
			.DATA_W(DATA_W),
			.HAS_COUNT(FULL)
		) u_ch (
			.clk_in(clk_in),
			.rst_n_in(rst_n_in),
			.ctl_in(ctl[g]),
			.lo_in(lo[g][ADDR_W-1:0]),
			.hi_in(hi[g][ADDR_W-1:0]),
			.dref_in(dref[g][DATA_W-1:0]),
			.dmask_in(dmask[g][DATA_W-1:0]),
			.cnt_in(cnt[g][15:0]),
			.dly_in(dly[g][15:0]),
			.enable_in(act[g][A_EN]), // R1
			.arm_in(arm[g]),
			.valid_in(bus_valid_in),
			.addr_in(bus_addr_in),
			.data_in(bus_data_in),
			.write_in(bus_write_in),
			.word_in(bus_word_in),
			.class_in(bus_class_in),
			.area_in(bus_area_in),
			.probe_in(probe_in),
			.event_out(ev[g])
		);
	end

	// Software and on-chip breakpoints
	bed_swbrk #(
		.ADDR_W(ADDR_W),
		.NUM(NUM_SW)
	) u_swbrk (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.wr_in(wr_entry),
		.idx_in(sw_idx),
		.entry_addr_in(reg_wdata_in[ADDR_W-1:0]),
		.entry_valid_in(reg_wdata_in[ENTRY_VALID]),
		.sw_en_in(brk_ctl[BC_SW_EN]),
		.ocb_en_in(brk_ctl[BC_OCB_EN]),
		.ocb_addr_in(ocb_addr[ADDR_W-1:0]),
		.valid_in(bus_valid_in),
		.addr_in(bus_addr_in),
		.class_in(bus_class_in),
		.area_in(bus_area_in),
		.sw_hit_out(sw_hit),
		.ocb_hit_out(ocb_hit)
	);

	// Action decode; stop wins when start and stop coincide
	wire logic any_brk = |(ev & a_brk) || sw_hit || ocb_hit; // R6
	wire logic next_timer = (timer_run || |(ev & a_tstart)) && !(|(ev & a_tstop));
	wire logic next_trace = (trace_run || |(ev & a_trstart)) && !(|(ev & a_trstop));
	wire logic cls_legal = bus_class_in < 3'(CLS_NUM);
	wire logic sup_hit = bus_valid_in && cls_legal && suppress[bus_class_in];
	wire logic acc_rng = bus_addr_in >= lo[ACC_CH][ADDR_W-1:0] &&
		bus_addr_in <= hi[ACC_CH][ADDR_W-1:0];
	wire logic acc_hit = bus_valid_in && cls_legal && acc_type[bus_class_in] && acc_rng;

	// Flags: a new event wins over a clear in the same cycle
	wire logic [ST_W-1:0] st_set = {ocb_hit, sw_hit, ev};
	wire logic [ST_W-1:0] st_clr = wr_status ? reg_wdata_in[ST_W-1:0] : '0;
	wire logic [ST_W-1:0] next_status = (status & ~st_clr) | st_set;
	wire logic [ST_W-1:0] next_mask =
		gw && reg_f == G_MASK ? reg_wdata_in[ST_W-1:0] : mask;
	wire logic [NUM_FULL-1:0] next_fired =
		(wr_seq_clr ? '0 : fired) | ev[NUM_FULL-1:0]; // R4

	// Channel read selection
	wire logic [31:0] ch_word =
		reg_f == R_CTL ? ctl[ch_f] :
		reg_f == R_LO ? lo[ch_f] :
		reg_f == R_HI ? hi[ch_f] :
		reg_f == R_DREF ? dref[ch_f] :
		reg_f == R_DMASK ? dmask[ch_f] :
		reg_f == R_ACT ? act[ch_f] :
		reg_f == R_CNT ? cnt[ch_f] : dly[ch_f];
	// Global read selection, run word shows live state
	wire logic [31:0] glb_word =
		reg_f == G_STATUS ? 32'(status) :
		reg_f == G_MASK ? 32'(mask) :
		reg_f == G_OCB_ADDR ? ocb_addr :
		reg_f == G_BRK_CTL ? 32'(brk_ctl) :
		reg_f == G_SW_IDX ? 32'(sw_idx) :
		reg_f == G_RUN ? {16'h0, fired, 6'h0, trace_run, timer_run} :
		reg_f == G_SUPPRESS ? 32'(suppress) :
		reg_f == G_ACC_TYPE ? 32'(acc_type) :
		reg_f == G_ACC_CNT ? acc_cnt : 32'h0;
	wire logic [31:0] rd_word = ch_ok ? ch_word : glb ? glb_word : 32'h0;

	// Channel configuration writes
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				ctl[i] <= CTL_RST;
				lo[i] <= WORD_RST;
				hi[i] <= WORD_RST;
				dref[i] <= WORD_RST;
				dmask[i] <= WORD_RST;
				act[i] <= WORD_RST;
				cnt[i] <= WORD_RST;
				dly[i] <= WORD_RST;
			end
		end
		else if (reg_wr_in && ch_ok)
		begin
			unique case (reg_f)
				R_CTL: ctl[ch_f] <= reg_wdata_in;
				R_LO: lo[ch_f] <= reg_wdata_in;
				R_HI: hi[ch_f] <= reg_wdata_in;
				R_DREF: dref[ch_f] <= reg_wdata_in;
				R_DMASK: dmask[ch_f] <= reg_wdata_in;
				R_ACT: act[ch_f] <= reg_wdata_in;
				R_CNT: cnt[ch_f] <= reg_wdata_in;
				R_DLY: dly[ch_f] <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// Global control writes
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			mask <= '0;
			ocb_addr <= WORD_RST;
			brk_ctl <= 2'h0;
			sw_idx <= 8'h0;
			suppress <= 6'h0;
			acc_type <= 6'h0;
		end
		else if (gw)
		begin
			// Other global words are read only or handled elsewhere
			if (reg_f == G_MASK)
				mask <= reg_wdata_in[ST_W-1:0];
			if (reg_f == G_OCB_ADDR)
				ocb_addr <= reg_wdata_in;
			if (reg_f == G_BRK_CTL)
				brk_ctl <= reg_wdata_in[1:0];
			if (reg_f == G_SW_IDX)
				sw_idx <= reg_wdata_in[7:0];
			if (reg_f == G_SUPPRESS)
				suppress <= reg_wdata_in[5:0]; // R11
			if (reg_f == G_ACC_TYPE)
				acc_type <= reg_wdata_in[5:0]; // R11
		end
	end

	// Status, sequence flags and interrupt
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			status <= '0;
			fired <= '0;
			irq_out <= 1'b0;
		end
		else
		begin
			status <= next_status;
			fired <= next_fired;
			irq_out <= |(next_status & next_mask);
		end
	end

	// Access counter, a write clears it
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			acc_cnt <= 32'h0;
		else if (wr_acc)
			acc_cnt <= 32'h0;
		else if (acc_hit)
			acc_cnt <= acc_cnt + 32'h1; // R11
	end

	// Actions and trace record
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			break_out <= 1'b0;
			timer_run <= 1'b0;
			trace_run <= 1'b0;
			timer_run_out <= 1'b0;
			trace_en_out <= 1'b0;
			trace_class_out <= 3'h0;
		end
		else
		begin
			break_out <= any_brk; // R6
			timer_run <= next_timer; // R6
			trace_run <= next_trace; // R6
			timer_run_out <= next_timer;
			trace_en_out <= next_trace && !sup_hit; // R11
			if (bus_valid_in)
				trace_class_out <= bus_class_in; // R11
		end
	end

	// Trigger low from channel 8 event to end of the next bus cycle
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			trigger_output_probe_n_out <= 1'b1;
		else if (ev[TRIG_CH])
			trigger_output_probe_n_out <= 1'b0; // R12
		else if (bus_valid_in)
			trigger_output_probe_n_out <= 1'b1; // R12
	end

	// Read data stands one cycle only
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			reg_rdata_out <= 32'h0;
		else
			reg_rdata_out <= reg_rd_in ? rd_word : 32'h0;
	end

	a_trig_low: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R12
		ev[TRIG_CH] |=> !trigger_output_probe_n_out)
		else $error("trigger not driven low");
	a_trig_release: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R12
		!trigger_output_probe_n_out && bus_valid_in && !ev[TRIG_CH]
		|=> trigger_output_probe_n_out)
		else $error("trigger held past one bus cycle");
	a_break_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
		(|(ev & a_brk)) |=> break_out)
		else $error("break not raised for event");
	a_seq_wait: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
		act[1][A_SEQ] && !fired[0] |-> !arm[1])
		else $error("sequence stage armed early");
	a_irq_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		irq_out == |(status & mask))
		else $error("interrupt level disagrees with status");
	a_rdata_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!reg_rd_in |=> reg_rdata_out == 32'h0)
		else $error("read data outside read slot");
endmodule
`default_nettype wire

// ### rtl/bed_pkg.sv
// Package: register map, field layout and codes of the bus event detector
package bed_pkg;
	// Channel counts and table size
	localparam int NUM_FULL = 8;
	localparam int NUM_RANGE = 4;
	localparam int NUM_CH = 12;
	localparam int NUM_SW = 256;
	localparam int TRIG_CH = 7;
	localparam int ACC_CH = 8;
	// Register address: channel field and word field
	localparam int REG_AW = 10;
	localparam int CH_LSB = 6;
	localparam int REG_LSB = 2;
	localparam logic [3:0] CH_GLOBAL = 4'hf;
	// Per channel words
	localparam logic [3:0] R_CTL = 4'h0;
	localparam logic [3:0] R_LO = 4'h1;
	localparam logic [3:0] R_HI = 4'h2;
	localparam logic [3:0] R_DREF = 4'h3;
	localparam logic [3:0] R_DMASK = 4'h4;
	localparam logic [3:0] R_ACT = 4'h5;
	localparam logic [3:0] R_CNT = 4'h6;
	localparam logic [3:0] R_DLY = 4'h7;
	// Global words
	localparam logic [3:0] G_STATUS = 4'h0;
	localparam logic [3:0] G_MASK = 4'h1;
	localparam logic [3:0] G_OCB_ADDR = 4'h2;
	localparam logic [3:0] G_BRK_CTL = 4'h3;
	localparam logic [3:0] G_SW_IDX = 4'h4;
	localparam logic [3:0] G_SW_ENTRY = 4'h5;
	localparam logic [3:0] G_RUN = 4'h6;
	localparam logic [3:0] G_SEQ_CLR = 4'h7;
	localparam logic [3:0] G_SUPPRESS = 4'h8;
	localparam logic [3:0] G_ACC_TYPE = 4'h9;
	localparam logic [3:0] G_ACC_CNT = 4'ha;
	// Channel control word fields
	localparam int AM_LSB = 0;
	localparam int OUTSIDE = 2;
	localparam int DIR_LSB = 3;
	localparam int DCMP = 5;
	localparam int DMASK_EN = 6;
	localparam int SIZE_EN = 7;
	localparam int SIZE_WORD = 8;
	localparam int CLS_LSB = 9;
	localparam int CLS_DC = 15;
	localparam int AREA_LSB = 16;
	localparam int AREA_DC = 23;
	localparam int PRB_LSB = 24;
	localparam logic [1:0] AM_DC = 2'h0;
	localparam logic [1:0] AM_SINGLE = 2'h1;
	localparam logic [1:0] AM_RANGE = 2'h2;
	localparam logic [1:0] DIR_READ = 2'h1;
	localparam logic [1:0] DIR_WRITE = 2'h2;
	localparam logic [1:0] PRB_DC = 2'h0;
	localparam logic [1:0] PRB_HIGH = 2'h1;
	localparam logic [1:0] PRB_LOW = 2'h2;
	// Action word fields
	localparam int A_BREAK = 0;
	localparam int A_TSTART = 1;
	localparam int A_TSTOP = 2;
	localparam int A_TRSTART = 3;
	localparam int A_TRSTOP = 4;
	localparam int A_SEQ = 5;
	localparam int A_EN = 6;
	// Status, break control, table entry and run word fields
	localparam int ST_SW = 12;
	localparam int ST_OCB = 13;
	localparam int ST_W = 14;
	localparam int BC_SW_EN = 0;
	localparam int BC_OCB_EN = 1;
	localparam int ENTRY_VALID = 31;
	localparam int RUN_TIMER = 0;
	localparam int RUN_TRACE = 1;
	localparam int RUN_FIRED_LSB = 8;
	// Reset values: every term don't care, channel disabled
	localparam logic [31:0] CTL_RST = 32'h0080_8000;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	// Bus state classes
	localparam int CLS_NUM = 6;
	localparam logic [2:0] prefetch_cycle_class = 3'h0;
	localparam logic [2:0] data_cycle_class = 3'h1;
	localparam logic [2:0] refresh_cycle_class = 3'h2;
	localparam logic [2:0] dma_controller_cycle_class = 3'h3;
	localparam logic [2:0] transfer_controller_cycle_class = 3'h4;
	localparam logic [2:0] other_cycle_class = 3'h5;
	// Area classes
	localparam int AREA_NUM = 7;
	localparam logic [2:0] rom_area = 3'h0;
	localparam logic [2:0] ram_area = 3'h1;
	localparam logic [2:0] onchip_wide_io_area = 3'h2;
	localparam logic [2:0] onchip_narrow_io_area = 3'h3;
	localparam logic [2:0] external_wide_io_area = 3'h4;
	localparam logic [2:0] external_narrow_io_area = 3'h5;
	localparam logic [2:0] transfer_controller_ram_area = 3'h6;
endpackage

// ### rtl/bed_channel.sv
// One event channel: match terms, occurrence count and delay
`timescale 1ns/1ps
`default_nettype none
module bed_channel #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16,
	parameter bit HAS_COUNT = 1'b1
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Configuration
	input wire logic [31:0] ctl_in,
	input wire logic [ADDR_W-1:0] lo_in,
	input wire logic [ADDR_W-1:0] hi_in,
	input wire logic [DATA_W-1:0] dref_in,
	input wire logic [DATA_W-1:0] dmask_in,
	input wire logic [15:0] cnt_in,
	input wire logic [15:0] dly_in,
	input wire logic enable_in,
	input wire logic arm_in,
	// Target bus cycle
	input wire logic valid_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic write_in,
	input wire logic word_in,
	input wire logic [2:0] class_in,
	input wire logic [2:0] area_in,
	input wire logic [3:0] probe_in,
	// Event pulse
	output logic event_out
);
	import bed_pkg::*;

	// Address term, outside inverts any address match
	wire logic [1:0] am = ctl_in[AM_LSB +: 2];
	wire logic in_rng = addr_in >= lo_in && addr_in <= hi_in;
	wire logic addr_hit = am == AM_SINGLE ? addr_in == lo_in : am == AM_RANGE && in_rng;
	wire logic addr_ok = am == AM_DC ||
		(am != 2'h3 && (addr_hit ^ ctl_in[OUTSIDE])); // R2
	// Direction term, code zero takes either
	wire logic [1:0] dir = ctl_in[DIR_LSB +: 2];
	wire logic dir_ok = dir == 2'h0 || (dir == DIR_READ && !write_in) ||
		(dir == DIR_WRITE && write_in);
	// Mask applies to both sides before equality
	wire logic [DATA_W-1:0] msk = ctl_in[DMASK_EN] ? dmask_in : '1; // R13
	wire logic size_ok = !ctl_in[SIZE_EN] || word_in == ctl_in[SIZE_WORD];
	wire logic data_eq = (data_in & msk) == (dref_in & msk); // R13
	wire logic data_ok = !ctl_in[DCMP] || (data_eq && size_ok);
	// Class and area terms; codes past the table never match
	wire logic [5:0] cls_m = ctl_in[CLS_LSB +: 6];
	wire logic [6:0] area_m = ctl_in[AREA_LSB +: 7];
	wire logic cls_ok = ctl_in[CLS_DC] || (class_in < 3'h6 && cls_m[class_in]); // R9
	wire logic area_ok = ctl_in[AREA_DC] || (area_in < 3'h7 && area_m[area_in]); // R10
	// Probe terms, two bits each
	logic [3:0] prb_ok;
	for (genvar g = 0; g < 4; g++)
	begin : g_prb
		wire logic [1:0] pc = ctl_in[PRB_LSB + 2*g +: 2];
		assign prb_ok[g] = pc == PRB_DC || (pc == PRB_HIGH && probe_in[g]) ||
			(pc == PRB_LOW && !probe_in[g]);
	end
	// All enabled terms together
	wire logic raw_hit = enable_in && valid_in && addr_ok && dir_ok &&
		data_ok && cls_ok && area_ok && &prb_ok; // R14

	logic hit_q; // Registered match, one stage of latency
	logic [15:0] occ; // Occurrences seen so far
	logic [15:0] dcnt; // Delay remaining
	logic pend; // Delay running

	wire logic armed = hit_q && arm_in && !pend; // R4
	wire logic [16:0] occ_inc = {1'b0, occ} + 17'h1;
	wire logic reach = !HAS_COUNT || occ_inc >= {1'b0, cnt_in}; // R3
	wire logic fire = armed && reach; // R15

	// Capture stage
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			hit_q <= 1'b0;
		else
			hit_q <= raw_hit; // R5
	end

	// Occurrence counter, restarts once the count is reached
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			occ <= 16'h0;
		else if (armed)
			occ <= reach ? 16'h0 : occ_inc[15:0]; // R15
	end

	// Delay, further matches ignored while it runs
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pend <= 1'b0;
			dcnt <= 16'h0;
			event_out <= 1'b0;
		end
		else
		begin
			event_out <= (fire && dly_in == 16'h0) || (pend && dcnt == 16'h1);
			if (fire && dly_in != 16'h0)
			begin
				pend <= 1'b1; // R15
				dcnt <= dly_in;
			end
			else if (pend)
			begin
				dcnt <= dcnt - 16'h1;
				pend <= dcnt != 16'h1;
			end
		end
	end

	a_zero_delay: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R15
		fire && dly_in == 16'h0 |=> event_out)
		else $error("zero delay event missing");
	a_delay_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R15
		fire && dly_in == 16'h2 |=> !event_out [*2] ##1 event_out)
		else $error("delay of two cycles not kept");
	a_count_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R15
		event_out |-> $past(fire) || $past(pend))
		else $error("event without reaching count");
endmodule
`default_nettype wire

// ### rtl/bed_swbrk.sv
// Software breakpoint table and single on-chip ROM breakpoint
`timescale 1ns/1ps
`default_nettype none
module bed_swbrk #(
	parameter int ADDR_W = 24,
	parameter int NUM = 256
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Table write port
	input wire logic wr_in,
	input wire logic [$clog2(NUM)-1:0] idx_in,
	input wire logic [ADDR_W-1:0] entry_addr_in,
	input wire logic entry_valid_in,
	// Controls
	input wire logic sw_en_in,
	input wire logic ocb_en_in,
	input wire logic [ADDR_W-1:0] ocb_addr_in,
	// Target bus cycle
	input wire logic valid_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [2:0] class_in,
	input wire logic [2:0] area_in,
	// Hit pulses
	output logic sw_hit_out,
	output logic ocb_hit_out
);
	import bed_pkg::*;

	logic [ADDR_W-1:0] tbl_addr [NUM]; // Break addresses
	logic [NUM-1:0] tbl_valid; // Entry in use
	logic sw_any; // Any valid entry equals the bus address
	logic ocb_armed; // ROM address fetched, waiting for it to execute

	wire logic fetch = valid_in && class_in == prefetch_cycle_class;
	wire logic in_rom = area_in == rom_area;

	// Parallel search, costly in gates but keeps fetch-time halting
	always_comb
	begin
		sw_any = 1'b0;
		for (int i = 0; i < NUM; i++)
			if (tbl_valid[i] && tbl_addr[i] == addr_in)
				sw_any = 1'b1;
	end

	// Table entries, addresses need no reset
	always_ff @(posedge clk_in)
	begin
		if (wr_in)
			tbl_addr[idx_in] <= entry_addr_in;
	end

	// Valid bits
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			tbl_valid <= '0;
		else if (wr_in)
			tbl_valid[idx_in] <= entry_valid_in; // R7
	end

	// Table breaks on fetch outside ROM; ROM has only one breakpoint
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sw_hit_out <= 1'b0;
			ocb_hit_out <= 1'b0;
			ocb_armed <= 1'b0;
		end
		else
		begin
			sw_hit_out <= sw_en_in && fetch && !in_rom && sw_any; // R7
			ocb_hit_out <= ocb_en_in && ocb_armed && fetch; // R8
			if (!ocb_en_in || (ocb_armed && fetch))
				ocb_armed <= 1'b0;
			else if (fetch && in_rom && addr_in == ocb_addr_in)
				ocb_armed <= 1'b1; // R8
		end
	end

	a_rom_single: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
		sw_hit_out |-> $past(area_in) != rom_area)
		else $error("table breakpoint hit inside ROM");
endmodule
`default_nettype wire

// ### tb/bed_bus_model.sv
// Target bus model: one bus cycle per call, idle lines never hold
`timescale 1ns/1ps
`default_nettype none
module bed_bus_model (
	// Clock
	input wire logic clk_in,
	// Bus cycle towards the detector
	output logic valid_out,
	output logic [23:0] addr_out,
	output logic [15:0] data_out,
	output logic write_out,
	output logic [2:0] class_out,
	output logic [2:0] area_out
);
	// Idle bus at time zero
	initial
	begin
		valid_out = 1'b0;
		addr_out = 24'h000000;
		data_out = 16'h0000;
		write_out = 1'b0;
		class_out = 3'h5;
		area_out = 3'h1;
	end
	// Drive one cycle; released lines show the inverse, never a stale value
	task cycle(input logic [23:0] a, input logic [15:0] d,
		input logic [2:0] c);
		@(posedge clk_in);
		valid_out <= 1'b1;
		addr_out <= a;
		data_out <= d;
		write_out <= d[0];
		class_out <= c;
		area_out <= 3'h1;
		@(posedge clk_in);
		valid_out <= 1'b0;
		addr_out <= ~a;
		data_out <= ~d;
		write_out <= ~d[0];
		class_out <= ~c;
		area_out <= 3'h6;
	endtask
endmodule
`default_nettype wire

// ### tb/test_bed_top.sv
// Self-checking bench of the bus event detector
`timescale 1ns/1ps
`default_nettype none
module test_bed_top;
	import bed_pkg::*;
	// Register port and bench state
	logic clk_in, rst_n_in, wr, rd;
	logic [9:0] ra;
	logic [31:0] wd, rdat, v, seed;
	// Target bus and actions
	logic bv, bw, brk, trun, tren, trig_n, irq;
	logic [23:0] ba;
	logic [15:0] bd, r, d;
	logic [2:0] bc, bar, tcls;
	logic [3:0] pb;
	int num_errors, check_count, cyc, k;
	bed_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(ra),
		.reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdat), .bus_valid_in(bv), .bus_addr_in(ba),
		.bus_data_in(bd), .bus_write_in(bw), .bus_word_in(1'b1),
		.bus_class_in(bc), .bus_area_in(bar), .probe_in(pb),
		.break_out(brk), .timer_run_out(trun), .trace_en_out(tren),
		.trace_class_out(tcls), .trigger_output_probe_n_out(trig_n),
		.irq_out(irq));
	bed_bus_model bus (.clk_in(clk_in), .valid_out(bv), .addr_out(ba),
		.data_out(bd), .write_out(bw), .class_out(bc), .area_out(bar));
	// 25 MHz clock
	initial
	begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	// Hang guard, far above the expected run
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			finish_test();
		end
	end
	// Xorshift source, fixed start
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Masked data equality the detector should apply
	function logic dhit(input logic [15:0] x, y, m);
		return (x & m) == (y & m);
	endfunction
	// Compare and count
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// One-cycle register write
	task wrw(input logic [9:0] a, input logic [31:0] x);
		@(posedge clk_in);
		wr <= 1'b1;
		ra <= a;
		wd <= x;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask
	// Register read; data stands only in the following cycle
	task rdw(input logic [9:0] a);
		@(posedge clk_in);
		rd <= 1'b1;
		ra <= a;
		@(posedge clk_in);
		rd <= 1'b0;
		@(negedge clk_in);
		v = rdat;
	endtask
	// One bus cycle, then watch break or trigger for a few cycles
	task go(input logic [23:0] a, input logic [15:0] x, input logic [2:0] c,
		input int sel, input logic e, input string n);
		logic h;
		bus.cycle(a, x, c);
		h = 1'b0;
		repeat (8)
		begin
			@(negedge clk_in);
			if (sel == 0 ? brk === 1'b1 : trig_n === 1'b0)
				h = 1'b1;
		end
		chk(n, e, h);
	endtask
	// Counts, then the verdict
	task finish_test();
		$display("Checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		seed = 32'h9e2f384a;
		rst_n_in = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		ra = 10'h000;
		wd = 32'h0;
		pb = 4'h0;
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rdw(10'h000);
		chk("ctl reset", CTL_RST, v);
		rdw(10'h020);
		chk("unmapped", 32'h0, v);
		chk("trigger idle", 32'h1, trig_n);
		$display("test reset done");
		// Each class selected alone, the next class refused
		wrw(10'h014, 32'h41);
		wrw(10'h3c4, 32'h1);
		for (k = 0; k < CLS_NUM; k++)
		begin
			wrw(10'h000, 32'h0080_0000 | (32'h200 << k));
			go(rnd(), 16'h0, k[2:0], 0, 1'b1, "class hit");
			chk("trace class", k, tcls);
			go(rnd(), 16'h0, 3'((k + 1) % 6), 0, 1'b0, "class miss");
		end
		chk("irq", 32'h1, irq);
		rdw(10'h3c0);
		chk("status", 32'h1, v & 32'h1);
		wrw(10'h3c0, 32'h1);
		rdw(10'h3c0);
		chk("irq clear", 32'h0, irq);
		$display("test class done");
		// Masked data compare with random values
		wrw(10'h000, 32'h0080_8060);
		wrw(10'h010, 32'h0ff0);
		for (k = 0; k < 6; k++)
		begin
			r = rnd();
			wrw(10'h00c, {16'h0, r});
			d = k[0] ? r ^ 16'h0f00 : r ^ 16'hf00f;
			go(rnd(), d, 3'h1, 0, dhit(d, r, 16'h0ff0), "mask");
		end
		$display("test mask done");
		// Third occurrence fires on channel two
		wrw(10'h014, 32'h0);
		wrw(10'h040, 32'h0080_8001);
		wrw(10'h044, 32'h1234);
		wrw(10'h058, 32'h3);
		wrw(10'h054, 32'h41);
		for (k = 1; k < 4; k++)
			go(24'h001234, rnd(), 3'h1, 0, k == 3, "count");
		$display("test count done");
		// Trigger channel pulls its probe low
		wrw(10'h054, 32'h0);
		wrw(10'h1c0, 32'h0080_8001);
		wrw(10'h1c4, 32'h2000);
		wrw(10'h1d4, 32'h40);
		go(24'h002001, rnd(), 3'h1, 1, 1'b0, "trigger miss");
		go(24'h002000, rnd(), 3'h1, 1, 1'b1, "trigger hit");
		// Timer and trace start, no halt; channel two waits for it
		wrw(10'h000, 32'h0080_8001);
		wrw(10'h004, 32'h3000);
		wrw(10'h014, 32'h4a);
		wrw(10'h040, 32'h0280_8001);
		wrw(10'h058, 32'h0);
		wrw(10'h054, 32'h61);
		wrw(10'h3dc, 32'h0);
		go(24'h001234, rnd(), 3'h1, 0, 1'b0, "seq wait");
		go(24'h003000, rnd(), 3'h1, 0, 1'b0, "no break");
		chk("timer run", 32'h1, trun);
		chk("trace run", 32'h1, tren);
		// Probe one must be low for channel two
		@(posedge clk_in) pb <= 4'h1;
		go(24'h001234, rnd(), 3'h1, 0, 1'b0, "probe miss");
		@(posedge clk_in) pb <= 4'h0;
		go(24'h001234, rnd(), 3'h1, 0, 1'b1, "seq go");
		// Table breakpoint on a fetch outside ROM
		wrw(10'h3d0, 32'h5);
		wrw(10'h3d4, 32'h8000_4000);
		wrw(10'h3cc, 32'h1);
		go(24'h004000, rnd(), 3'h0, 0, 1'b1, "table break");
		$display("test action done");
		finish_test();
	end
endmodule
`default_nettype wire
